/* pws_sram_wr.sv */
`timescale 1ns/10ps
`include "pws_cfg.svh"

// write-side command pipeline of a pipelined synchronous sram
module pws_sram_wr (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [`PWS_ADDR_W-1:0] addr_i,
    input wire logic read_write_select_i,
    input wire logic advance_or_load_select_i,
    input wire logic chip_select_low_a_i,
    input wire logic chip_select_polarity_pair_i,
    input wire logic chip_select_low_b_i,
    input wire logic [`PWS_LANES-1:0] byte_lane_write_enables_b_i,
    input wire logic [`PWS_DATA_W-1:0] dq_i,
    output logic [`PWS_DATA_W-1:0] dq_o,
    output logic dq_oe_b_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [`PWS_ADDR_W-1:0] wr_addr_o,
    output logic [`PWS_LANES-1:0] wr_be_o,
    output logic [`PWS_DATA_W-1:0] wr_data_o,
    output logic wr_overflow_o
);

    // chip counts as selected only with every enable at its active level
    function automatic logic chip_sel(input logic ce_a_b, input logic ce_hi, input logic ce_b_b);
        chip_sel = (ce_a_b == `PWS_ACT_LOW) && ce_hi && (ce_b_b == `PWS_ACT_LOW);
    endfunction

    pws_pkg::pws_top_st_t st_q;
    pws_pkg::pws_top_st_t st_d;
    logic [`PWS_LANES-1:0] be_act;
    logic sel;
    logic load;
    logic start;
    logic push;
    pws_pkg::pws_word_t push_word;

    pws_wr_if cap_if ();
    pws_wr_if out_if ();

    // per-lane conversion of the active-low byte enables
    genvar gi;
    generate
        for (gi = 0; gi < `PWS_LANES; gi++) begin : g_lane
            assign be_act[gi] = (byte_lane_write_enables_b_i[gi] == `PWS_ACT_LOW);
        end
    endgenerate

    // decode of the command sampled on this edge
    assign sel = chip_sel(chip_select_low_a_i, chip_select_polarity_pair_i, chip_select_low_b_i);
    assign load = !advance_or_load_select_i;
    assign start = load && sel && !read_write_select_i;

    // data for the command loaded two edges ago is on the pins now
    assign push = st_q.p2.valid;
    // one driver for the whole word: address and enables from the stage, data from the pins
    assign push_word = {st_q.p2.addr, st_q.p2.be, dq_i};

    assign cap_if.valid = push;
    assign cap_if.word = push_word;

    // pipeline advance; a deselect or read load only fills a bubble
    always_comb begin
        st_d = st_q;
        st_d.p1.valid = start;
        st_d.p1.addr = start ? addr_i : st_q.p1.addr;
        st_d.p1.be = start ? be_act : st_q.p1.be;
        st_d.p2 = st_q.p1;
        // the bus cannot be stalled, so a full buffer can only flag the loss
        if (push && !cap_if.ready) begin
            st_d.ovf = 1'h1;
        end
    end

    // state register; reset empties both stages and clears the loss flag
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    pws_wbuf u_wbuf (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .in_port(cap_if.snk),
        .out_port(out_if.src)
    );

    // array-side port
    assign wr_valid_o = out_if.valid;
    assign out_if.ready = wr_ready_i;
    assign wr_addr_o = out_if.word.addr;
    assign wr_be_o = out_if.word.be;
    assign wr_data_o = out_if.word.data;
    assign wr_overflow_o = st_q.ovf;

    // no read path here, so the data pins stay released at all times
    assign dq_o = '0;
    assign dq_oe_b_o = 1'h1;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    // a write load lands in the first stage with its address
    a_write_start_latch: assert property (
        start |=> st_q.p1.valid && st_q.p1.addr == $past(addr_i))
        else $error("write load not captured in first stage");

    // a read load must never turn into a data capture
    a_read_no_capture: assert property (
        load && sel && read_write_select_i |-> ##2 !push)
        else $error("read load produced a write capture");

    // a read load leaves the first stage empty
    a_read_no_start: assert property (
        load && sel && read_write_select_i |=> !st_q.p1.valid)
        else $error("read load started a write");

    // enables travel with the command until the data shows up
    a_be_two_early: assert property (
        start |-> ##2 (push && push_word.be == $past(be_act, 2)))
        else $error("byte enables not paired with data two edges later");

    // pins are active low, the stage keeps them active high
    a_be_lane_map: assert property (
        start |=> st_q.p1.be == ~$past(byte_lane_write_enables_b_i))
        else $error("byte enables inverted wrongly");

    // with an empty buffer the captured data shows at the array port next cycle
    a_data_two_later: assert property (
        start ##2 (cap_if.ready && !wr_valid_o) |=> wr_data_o == $past(dq_i) && wr_addr_o == $past(addr_i, 3))
        else $error("data not captured two edges after its address");

    // every capture needs a write load two edges before
    a_no_spurious_cap: assert property (
        push |-> $past(start, 2))
        else $error("capture without a write load two edges before");

    // the second stage is always the first stage one edge late
    a_stage_shift: assert property (
        1'h1 |=> st_q.p2 == $past(st_q.p1))
        else $error("pipeline stage skipped");

    // a word taken into an empty buffer is offered with its address and enables on the next cycle
    a_first_word_out: assert property (
        push && cap_if.ready && !wr_valid_o |=> wr_valid_o && wr_addr_o == $past(push_word.addr) &&
            wr_be_o == $past(push_word.be))
        else $error("captured word not offered to the array");

    // a word the buffer took is never lost
    a_kept_word_valid: assert property (
        push && cap_if.ready |=> wr_valid_o)
        else $error("accepted word vanished");

    // a deselect does not cancel the write already in flight
    a_desel_pending: assert property (
        !sel && load ##1 1'h1 |-> $past(st_q.p1.valid) == push)
        else $error("pending write lost across a deselect");

    // pending write completes on the edge after the deselected edge
    a_pend_across_desel: assert property (
        st_q.p1.valid && !sel |=> push)
        else $error("pending write dropped during deselect");

    // no load, no new operation
    a_desel_no_start: assert property (
        (!sel || !load) |=> !st_q.p1.valid)
        else $error("new operation started while deselected");

    // advance cycles are treated as no operation
    a_adv_no_start: assert property (
        advance_or_load_select_i |=> !st_q.p1.valid)
        else $error("advance cycle started a write");

    // an empty buffer stays empty when nothing is captured
    a_idle_stays_idle: assert property (
        !wr_valid_o && !push |=> !wr_valid_o)
        else $error("word appeared with no capture");

    // all three enables must be active together
    a_cs_all_active: assert property (
        st_q.p1.valid |-> $past(!chip_select_low_a_i && chip_select_polarity_pair_i && !chip_select_low_b_i))
        else $error("write loaded without full chip select");

    // the high enable alone can deselect
    a_sel_needs_hi: assert property (
        !chip_select_polarity_pair_i |=> !st_q.p1.valid)
        else $error("write loaded with high enable inactive");

    // either low enable alone can deselect
    a_sel_needs_low: assert property (
        chip_select_low_a_i || chip_select_low_b_i |=> !st_q.p1.valid)
        else $error("write loaded with a low enable inactive");

    // pins stay released for three cycles from reset release
    a_pins_released: assert property (
        $rose(rst_b_i) |-> dq_oe_b_o [*3])
        else $error("data pins driven after reset release");

    // nothing is ever put on the data pins
    a_dq_out_idle: assert property (
        dq_o == '0 && dq_oe_b_o)
        else $error("data pins driven");

    // a word refused by a full buffer raises the loss flag
    a_overflow_flag: assert property (
        push && !cap_if.ready |=> wr_overflow_o)
        else $error("lost word not flagged");

    // the loss flag is sticky until reset
    a_ovf_sticky: assert property (
        wr_overflow_o |=> wr_overflow_o)
        else $error("loss flag cleared without reset");

    // the loss flag only rises after a refused word
    a_ovf_cause: assert property (
        $rose(wr_overflow_o) |-> $past(push && !cap_if.ready))
        else $error("loss flag raised with no lost word");

endmodule

/* pws_cfg.svh */
`ifndef PWS_CFG_SVH
`define PWS_CFG_SVH

// array geometry of the wide organisation
`define PWS_ADDR_W 18
`define PWS_DATA_W 36
`define PWS_LANES 4

// edges between a command load and its data capture
`define PWS_WR_LAT 2

// depth of the buffer that decouples the bus from the array port
`define PWS_BUF_DEPTH 2

// active level of the two low chip selects and of the byte enables
`define PWS_ACT_LOW 1'h0

`endif

/* pws_pkg.sv */
`include "pws_cfg.svh"

package pws_pkg;

    // command held in each pipeline stage between load and data
    typedef struct packed {
        logic valid;
        logic [`PWS_ADDR_W-1:0] addr;
        logic [`PWS_LANES-1:0] be;
    } pws_cmd_t;

    // one complete write handed to the array
    typedef struct packed {
        logic [`PWS_ADDR_W-1:0] addr;
        logic [`PWS_LANES-1:0] be;
        logic [`PWS_DATA_W-1:0] data;
    } pws_word_t;

    // whole state of the front end
    typedef struct packed {
        pws_cmd_t p1;
        pws_cmd_t p2;
        logic ovf;
    } pws_top_st_t;

    // whole state of the two-entry buffer
    typedef struct packed {
        logic [`PWS_BUF_DEPTH-1:0][$bits(pws_word_t)-1:0] ent;
        logic head;
        logic [1:0] cnt;
    } pws_buf_st_t;

endpackage

/* pws_wr_if.sv */
`timescale 1ns/10ps

// valid/ready carrier for finished write words
interface pws_wr_if;
    logic valid;
    logic ready;
    pws_pkg::pws_word_t word;

    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface

/* pws_wbuf.sv */
`timescale 1ns/10ps

// two-entry buffer so an array stall loses no captured word until both entries are full
module pws_wbuf (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    pws_wr_if.snk in_port,
    pws_wr_if.src out_port
);

    pws_pkg::pws_buf_st_t st_q;
    pws_pkg::pws_buf_st_t st_d;
    logic push;
    logic pop;
    logic widx;

    // handshakes straight from the fill count
    assign in_port.ready = (st_q.cnt != 2'h2);
    assign out_port.valid = (st_q.cnt != 2'h0);
    assign out_port.word = pws_pkg::pws_word_t'(st_q.ent[st_q.head]);
    assign push = in_port.valid && in_port.ready;
    assign pop = out_port.valid && out_port.ready;
    assign widx = st_q.head ^ (st_q.cnt == 2'h1);

    // next state: write at the head when empty, else behind it, advance head on pop
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.ent[widx] = in_port.word;
        end
        if (pop) begin
            st_d.head = ~st_q.head;
        end
        case ({push, pop})
            2'h2: st_d.cnt = st_q.cnt + 2'h1;
            2'h1: st_d.cnt = st_q.cnt - 2'h1;
            default: st_d.cnt = st_q.cnt;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_buf_no_overfill: assert property (st_q.cnt <= 2'h2)
        else $error("buffer count above depth");
    a_buf_hold_stall: assert property (out_port.valid && !out_port.ready |=> out_port.valid && $stable(out_port.word))
        else $error("buffered word changed while stalled");

endmodule

/* pws_ctl_model.sv */
`timescale 1ns/10ps
`include "pws_cfg.svh"

// controller side of the bus: loads commands, sends write data two cycles on
module pws_ctl_model (
    input wire logic mclk_i,
    output logic [`PWS_ADDR_W-1:0] addr_o,
    output logic rw_o,
    output logic adv_o,
    output logic [2:0] cs_o,
    output logic [`PWS_LANES-1:0] be_b_o,
    output logic [`PWS_DATA_W-1:0] dq_o
);
    logic [`PWS_DATA_W-1:0] d1, d2;
    logic v1 = 1'h0;
    logic v2 = 1'h0;

    // start deselected, cs bits are {low a, pair, low b}
    initial begin
        addr_o = 18'h0;
        rw_o = 1'h1;
        adv_o = 1'h0;
        cs_o = 3'h7;
        be_b_o = 4'hF;
        dq_o = 36'h0;
    end

    // one bus cycle off the falling edge; kind 0 write, 1 read, 2 deselect, 3 advance
    task automatic step(input int kind, input logic [17:0] a, input logic [3:0] be, input logic [35:0] d);
        @(negedge mclk_i);
        // released bus shows the inverse so stale data never matches by luck
        dq_o = v2 ? d2 : ~dq_o;
        addr_o = a;
        rw_o = kind != 0;
        adv_o = kind == 3;
        cs_o = kind == 2 ? 3'h2 ^ 3'(1 << ($urandom() % 3)) : 3'h2;
        be_b_o = kind == 0 ? be : ~be;
        v2 = v1;
        d2 = d1;
        v1 = kind == 0;
        d1 = d;
    endtask
endmodule

/* pws_sram_wr_tb_top.sv */
`timescale 1ns/10ps
`include "pws_cfg.svh"

// random write traffic against a queue model of the words the array must see
module pws_sram_wr_tb_top;
    logic mclk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic wr_ready_i = 1'h1;
    logic [17:0] addr, wr_addr_o;
    logic rw, adv, full_pre, dq_oe_b_o, wr_valid_o, wr_overflow_o;
    logic [2:0] cs;
    logic [3:0] be_b, wr_be_o;
    logic [35:0] dq_i, dq_o, wr_data_o;
    int err_total = 0;
    int cmp_count = 0;
    logic [57:0] mq[$];
    logic [21:0] lp1, lp2;
    logic lv1 = 1'h0;
    logic lv2 = 1'h0;
    logic exp_ovf = 1'h0;

    always #10 mclk_i = ~mclk_i;

    pws_ctl_model ctl (.mclk_i(mclk_i), .addr_o(addr), .rw_o(rw), .adv_o(adv), .cs_o(cs),
        .be_b_o(be_b), .dq_o(dq_i));

    pws_sram_wr uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr), .read_write_select_i(rw),
        .advance_or_load_select_i(adv), .chip_select_low_a_i(cs[2]), .chip_select_polarity_pair_i(cs[1]),
        .chip_select_low_b_i(cs[0]), .byte_lane_write_enables_b_i(be_b), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe_b_o(dq_oe_b_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
        .wr_be_o(wr_be_o), .wr_data_o(wr_data_o), .wr_overflow_o(wr_overflow_o));

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // model: pop on ready, push the word whose data is due now, drop when full
    always @(posedge mclk_i) begin
        // the buffer refuses on its count before this edge's pop
        full_pre = mq.size() >= `PWS_BUF_DEPTH;
        if (!rst_b_i) begin
            mq = {};
            lv1 = 1'h0;
            lv2 = 1'h0;
            exp_ovf = 1'h0;
        end else begin
            if (mq.size() > 0 && wr_ready_i) begin
                chk("word", {6'h0, mq[0]}, {6'h0, wr_addr_o, wr_be_o, wr_data_o});
                void'(mq.pop_front());
            end
            // data of a load two edges back lands even while a new load is taken
            if (lv2 && !full_pre) mq.push_back({lp2, dq_i});
            else if (lv2) exp_ovf = 1'h1;
            lp2 = lp1;
            lv2 = lv1;
            lv1 = !adv && !rw && cs == 3'h2;
            lp1 = {addr, ~be_b};
        end
    end

    // settled outputs are looked at mid-cycle
    always @(negedge mclk_i) begin
        if (rst_b_i) begin
            chk("valid", {63'h0, mq.size() != 0}, {63'h0, wr_valid_o});
            chk("overflow", {63'h0, exp_ovf}, {63'h0, wr_overflow_o});
        end
        chk("oe_b", 64'h1, {63'h0, dq_oe_b_o});
        chk("dq_out", 64'h0, {28'h0, dq_o});
    end

    // random mix of writes, reads, deselects and advances, then a forced overflow
    initial begin
        int k;
        void'($urandom(32'h9B2E));
        repeat (8) @(negedge mclk_i);
        rst_b_i = 1'h1;
        for (int i = 0; i < 800; i++) begin
            k = $urandom() % 6;
            ctl.step(k > 3 ? 0 : k, 18'($urandom()), 4'($urandom()), 36'({$urandom(), $urandom()}));
            wr_ready_i = ($urandom() % 4) != 0;
        end
        wr_ready_i = 1'h0;
        for (int i = 0; i < 10; i++) begin
            ctl.step(i < 5 ? 0 : 2, 18'($urandom()), 4'h0, 36'({$urandom(), $urandom()}));
        end
        wr_ready_i = 1'h1;
        repeat (6) ctl.step(2, 18'h0, 4'h0, 36'h0);
        @(posedge mclk_i);
        close_out();
    end
endmodule
